// ---- scfc_chopper.sv ----
// Top module: fixed off-time chopper with dead time, blanking and latched protection
`timescale 1ns/100ps
module scfc_chopper
   import scfc_pkg::*;
#(
   parameter bit BLANK_LONG = 1'b1
)(
   input  wire logic              core_clk,
   input  wire logic              rst,
   input  wire logic              enable,
   input  wire logic [PROP_W-1:0] step_proportion,
   input  wire logic [PROP_W-1:0] ext_reference,
   input  wire scfc_sense_s       sense_pins,
   input  wire logic              over_temp,
   output logic [DAC_W-1:0]       trip_reference,
   output scfc_gate_s             gates,
   output scfc_fault_s            fault_latches,
   output logic                   fault
);
   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   // Comparator outputs are asynchronous; three stages, change counts when 2nd and 3rd agree
   logic [3:0] sy1_r, sy2_r, sy3_r, in_r;
   logic [3:0] raw;
   assign raw = {over_temp, sense_pins.trip, sense_pins.short_hit, sense_pins.positive};

   always_ff @(posedge core_clk) begin
      if (rst) begin
         sy1_r <= 4'h0;
         sy2_r <= 4'h0;
         sy3_r <= 4'h0;
      end else begin
         sy1_r <= raw;
         sy2_r <= sy1_r;
         sy3_r <= sy2_r;
      end
   end

   generate
      for (genvar i = 0; i < 4; i++) begin : g_agree
         always_ff @(posedge core_clk) begin
            if (rst) begin
               in_r[i] <= 1'b0;
            end else if (sy2_r[i] == sy3_r[i]) begin
               in_r[i] <= sy3_r[i];
            end
         end
      end
   endgenerate

   logic s_pos, s_short, s_trip, s_hot;
   assign s_pos   = in_r[0];
   assign s_short = in_r[1];
   assign s_trip  = in_r[2];
   assign s_hot   = in_r[3];

   // ----------------------------------------
   // Trip reference
   // ----------------------------------------
   always_ff @(posedge core_clk) begin
      if (rst) begin
         trip_reference <= 16'h0000;
      end else begin
         trip_reference <= ext_reference * step_proportion;
      end
   end

   // ----------------------------------------
   // Off interval selection
   // ----------------------------------------
   // Lower proportion means a longer off interval to let small currents decay
   logic [CNT_W-1:0] off_len;
   always_comb begin
      if (step_proportion >= PROP_HI) begin
         off_len = CNT_W'(OFF_LOW_CYC);
      end else if (step_proportion >= PROP_LO) begin
         off_len = CNT_W'(OFF_MID_CYC);
      end else begin
         off_len = CNT_W'(OFF_HIGH_CYC);
      end
   end

   logic [CNT_W-1:0] blank_len;
   assign blank_len = BLANK_LONG ? CNT_W'(BLANK_LONG_CYC) : CNT_W'(BLANK_SHORT_CYC);

   // ----------------------------------------
   // Protection latches
   // ----------------------------------------
   scfc_state_e      state_r;
   logic [CNT_W-1:0] cnt_r;
   logic [1:0]       open_cnt_r;
   logic             open_seen_r;
   logic             short_r;
   logic             open_r;
   logic             therm_r;
   logic             any_fault;
   logic             open_trip;
   logic             stop_now;
   assign any_fault     = short_r | open_r | therm_r;
   assign fault_latches = '{short_f: short_r, open_f: open_r, therm_f: therm_r};

   always_ff @(posedge core_clk) begin
      if (rst) begin
         short_r <= 1'b0;
         therm_r <= 1'b0;
      end else begin
         if (s_short) begin
            short_r <= 1'b1;
         end
         if (s_hot) begin
            therm_r <= 1'b1;
         end
      end
   end

   // Open-coil hit is remembered per off interval, judged when the interval ends
   logic off_end;
   assign off_end   = (state_r == SCFC_OFF) && (cnt_r == '0);
   assign open_trip = off_end && (open_seen_r || s_pos) && (open_cnt_r == 2'(OPEN_HITS - 1));
   // Outputs drop on the very edge that latches, so no switch conducts while the fault shows
   assign stop_now  = any_fault | s_short | s_hot | open_trip;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         open_seen_r <= 1'b0;
      end else if (off_end) begin
         open_seen_r <= 1'b0;
      end else if (state_r == SCFC_OFF && s_pos) begin
         open_seen_r <= 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         open_cnt_r <= 2'h0;
         open_r     <= 1'b0;
      end else if (open_trip) begin
         open_r <= 1'b1;
      end else if (off_end) begin
         if (open_seen_r || s_pos) begin
            open_cnt_r <= open_cnt_r + 2'h1;
         end else begin
            open_cnt_r <= 2'h0;
         end
      end
   end

   assign fault = any_fault;

   // ----------------------------------------
   // Chopper state machine
   // ----------------------------------------
   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_r <= SCFC_IDLE;
         cnt_r   <= '0;
      end else if (stop_now) begin
         state_r <= SCFC_FAULT;
         cnt_r   <= '0;
      end else begin
         case (state_r)
            SCFC_IDLE: begin
               if (enable) begin
                  state_r <= SCFC_DEAD_ON;
                  cnt_r   <= CNT_W'(DEAD_CYC - 1);
               end
            end
            SCFC_DEAD_ON: begin
               if (cnt_r == '0) begin
                  state_r <= SCFC_ON;
                  cnt_r   <= blank_len - CNT_W'(1);
               end else begin
                  cnt_r <= cnt_r - CNT_W'(1);
               end
            end
            SCFC_ON: begin
               if (cnt_r != '0) begin
                  cnt_r <= cnt_r - CNT_W'(1);
               end else if (s_trip || !enable) begin
                  state_r <= SCFC_DEAD_OF;
                  cnt_r   <= CNT_W'(DEAD_CYC - 1);
               end
            end
            SCFC_DEAD_OF: begin
               if (cnt_r == '0) begin
                  state_r <= SCFC_OFF;
                  cnt_r   <= off_len - CNT_W'(1);
               end else begin
                  cnt_r <= cnt_r - CNT_W'(1);
               end
            end
            SCFC_OFF: begin
               if (cnt_r == '0) begin
                  state_r <= enable ? SCFC_DEAD_ON : SCFC_IDLE;
                  cnt_r   <= CNT_W'(DEAD_CYC - 1);
               end else begin
                  cnt_r <= cnt_r - CNT_W'(1);
               end
            end
            SCFC_FAULT: begin
               state_r <= SCFC_FAULT;
            end
            default: begin
               state_r <= SCFC_FAULT;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Gate drive
   // ----------------------------------------
   // Gates come from flops one cycle behind state_r; both are low from the second cycle of a dead state and in fault
   always_ff @(posedge core_clk) begin
      if (rst) begin
         gates <= '0;
      end else if (stop_now) begin
         gates <= '0;
      end else begin
         gates.on_sw   <= (state_r == SCFC_ON);
         gates.rect_sw <= (state_r == SCFC_OFF);
      end
   end
endmodule

// ---- scfc_chopper_sva.sv ----
// Checker: concurrent properties on the chopper top-level ports
`timescale 1ns/100ps
module scfc_chopper_sva
   import scfc_pkg::*;
#(
   parameter bit BLANK_LONG = 1'b1
)(
   input wire logic              core_clk,
   input wire logic              rst,
   input wire logic              enable,
   input wire logic [PROP_W-1:0] step_proportion,
   input wire logic [PROP_W-1:0] ext_reference,
   input wire scfc_sense_s       sense_pins,
   input wire logic              over_temp,
   input wire logic [DAC_W-1:0]  trip_reference,
   input wire scfc_gate_s        gates,
   input wire scfc_fault_s       fault_latches,
   input wire logic              fault
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   localparam int unsigned BLANK_CYC = BLANK_LONG ? BLANK_LONG_CYC : BLANK_SHORT_CYC;
   logic [CNT_W-1:0] on_cnt_r;
   logic [CNT_W-1:0] off_cnt_r;
   // ----------------------------------------
   // Phase length counters
   // ----------------------------------------
   always_ff @(posedge core_clk) begin
      on_cnt_r <= (rst || !gates.on_sw) ? '0 : on_cnt_r + 1'b1;
   end
   always_ff @(posedge core_clk) begin
      off_cnt_r <= (rst || !gates.rect_sw) ? '0 : off_cnt_r + 1'b1;
   end
   sequence rect_stays_low;
      !gates.rect_sw [*8];
   endsequence
   sequence on_stays_low;
      !gates.on_sw [*8];
   endsequence
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   AST_NO_OVERLAP: assert property (!(gates.on_sw && gates.rect_sw))
      else $error("Both switches conduct together");
   AST_DEAD_AFTER_ON: assert property ($fell(gates.on_sw) |-> rect_stays_low)
      else $error("Recirculation switch closed too soon");
   AST_DEAD_AFTER_OFF: assert property ($fell(gates.rect_sw) |-> on_stays_low)
      else $error("Energised switch closed too soon");
   AST_RECT_AFTER_DEAD: assert property ($fell(gates.on_sw) && !fault |-> ##13 (gates.rect_sw || fault))
      else $error("Recirculation not started after dead gap");
   AST_ON_MIN: assert property ($fell(gates.on_sw) && !fault |-> on_cnt_r >= BLANK_CYC)
      else $error("On phase shorter than blanking");
   AST_OFF_LEN: assert property ($fell(gates.rect_sw) && !fault |-> off_cnt_r == OFF_LOW_CYC ||
      off_cnt_r == OFF_MID_CYC || off_cnt_r == OFF_HIGH_CYC) else $error("Off interval not a fixed level");
   AST_TRIP_REF: assert property (!$past(rst) |-> trip_reference == 16'($past(ext_reference)) * 16'($past(step_proportion)))
      else $error("Trip reference not scaled");
   AST_FAULT_OR: assert property (fault == (|fault_latches))
      else $error("Fault output differs from latches");
   AST_STICKY: assert property (1'b1 |=> (fault_latches & $past(fault_latches)) == $past(fault_latches))
      else $error("Fault latch cleared without reset");
   AST_FAULT_GATES: assert property (fault |-> gates == 2'b00)
      else $error("Switch on while faulted");
   AST_SHORT: assert property (sense_pins.short_hit [*6] |=> ##[0:2] fault_latches.short_f)
      else $error("Short not latched");
   AST_THERM: assert property (over_temp [*6] |=> ##[0:2] fault_latches.therm_f)
      else $error("Over temperature not latched");
endmodule
bind scfc_chopper scfc_chopper_sva #(.BLANK_LONG(BLANK_LONG)) scfc_chopper_sva_i (.core_clk(core_clk), .rst(rst),
   .enable(enable), .step_proportion(step_proportion), .ext_reference(ext_reference), .sense_pins(sense_pins),
   .over_temp(over_temp), .trip_reference(trip_reference), .gates(gates), .fault_latches(fault_latches), .fault(fault));

// ---- scfc_pkg.sv ----
// Package: constants and carrier types for the stepper chopper and fault control block
package scfc_pkg;
   // ----------------------------------------
   // Clock and timing
   // ----------------------------------------
   localparam int unsigned CLK_HZ         = 25000000;
   localparam int unsigned DEAD_NS        = 500;
   localparam int unsigned BLANK_SHORT_NS = 1700;
   localparam int unsigned BLANK_LONG_NS  = 3200;
   localparam int unsigned OFF_LOW_NS     = 7000;
   localparam int unsigned OFF_MID_NS     = 9500;
   localparam int unsigned OFF_HIGH_NS    = 12000;
   localparam int unsigned CLK_NS         = 1000000000 / CLK_HZ;
   // Least times round up, longest times round down
   localparam int unsigned DEAD_CYC        = (DEAD_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned BLANK_SHORT_CYC = (BLANK_SHORT_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned BLANK_LONG_CYC  = (BLANK_LONG_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned OFF_LOW_CYC     = (OFF_LOW_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned OFF_MID_CYC     = (OFF_MID_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned OFF_HIGH_CYC    = OFF_HIGH_NS / CLK_NS;
   localparam int unsigned OPEN_HITS       = 3;
   // ----------------------------------------
   // Widths and proportion thresholds
   // ----------------------------------------
   localparam int unsigned CNT_W   = 9;
   localparam int unsigned PROP_W  = 8;
   localparam int unsigned DAC_W   = 16;
   localparam logic [7:0]  PROP_HI = 8'hAA;
   localparam logic [7:0]  PROP_LO = 8'h55;
   // ----------------------------------------
   // Types
   // ----------------------------------------
   // One bit changes per step around the chopping loop, including the wrap from off back to dead
   typedef enum logic [2:0] {
      SCFC_IDLE    = 3'b100,
      SCFC_DEAD_ON = 3'b000,
      SCFC_ON      = 3'b001,
      SCFC_DEAD_OF = 3'b011,
      SCFC_OFF     = 3'b010,
      SCFC_FAULT   = 3'b110
   } scfc_state_e;

   typedef struct packed {
      logic trip;      // Sense voltage at or above trip reference
      logic short_hit; // Sense voltage above short_trip_threshold
      logic positive;  // Sense voltage above zero
   } scfc_sense_s;

   typedef struct packed {
      logic on_sw;     // Switch on the energised side
      logic rect_sw;   // Opposite switch used for recirculation
   } scfc_gate_s;

   typedef struct packed {
      logic short_f;
      logic open_f;
      logic therm_f;
   } scfc_fault_s;
endpackage

// ---- scfc_stage_model.sv ----
// Partner model: switch stage and its sense comparators
`timescale 1ns/100ps
module scfc_stage_model
   import scfc_pkg::*;
(
   input  wire scfc_gate_s  gates,
   input  wire logic        open_coil,
   input  wire logic        coil_short,
   output scfc_sense_s      sense_pins
);
   // Trip is high from turn-on, so only blanking keeps the on phase alive
   assign sense_pins.trip      = gates.on_sw;
   // A broken coil shows positive sense only while recirculating
   assign sense_pins.positive  = open_coil && gates.rect_sw;
   assign sense_pins.short_hit = coil_short;
endmodule

// ---- tb_top.sv ----
// Testbench: chopper timing and protection scenarios
`timescale 1ns/100ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin failures++; $display("MISMATCH t=%0t got=%0h exp=%0h", $time, g, e); end end
module tb_top
   import scfc_pkg::*;
;
   logic core_clk = 0, rst = 1, enable = 0, over_temp = 0, open_coil = 0, coil_short = 0;
   logic [PROP_W-1:0] step_proportion = '0, ext_reference = '0;
   logic [DAC_W-1:0] trip_reference;
   scfc_sense_s sense_pins;
   scfc_gate_s gates;
   scfc_fault_s fault_latches;
   logic fault;
   int failures = 0, n_compared = 0;
   always #20 core_clk = ~core_clk;
   scfc_chopper #(.BLANK_LONG(1'b1)) scfc_chopper_i (.core_clk(core_clk), .rst(rst), .enable(enable),
      .step_proportion(step_proportion), .ext_reference(ext_reference), .sense_pins(sense_pins),
      .over_temp(over_temp), .trip_reference(trip_reference), .gates(gates), .fault_latches(fault_latches), .fault(fault));
   scfc_stage_model scfc_stage_model_i (.gates(gates), .open_coil(open_coil), .coil_short(coil_short),
      .sense_pins(sense_pins));
   task automatic tally_and_finish;
      $display("Compared %0d, mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // Bounded wait, sampled on the falling edge away from output updates
   task automatic wait_sw(input bit rect, input bit val, output int n);
      n = 0;
      while ((rect ? gates.rect_sw : gates.on_sw) !== val && n < 1000) begin
         @(negedge core_clk);
         n++;
      end
      if (n >= 1000) failures++;
   endtask
   task automatic do_reset;
      @(posedge core_clk);
      {rst, enable, open_coil, coil_short, over_temp} <= 5'b10000;
      repeat (6) @(posedge core_clk);
      rst <= 1'b0;
      @(negedge core_clk);
      `CHK({gates, fault_latches, fault}, 6'h00)
   endtask
   task automatic chop_levels;
      logic [7:0] props [3] = '{8'hAA, 8'h55, 8'h54};
      int exp_off [3] = '{OFF_LOW_CYC, OFF_MID_CYC, OFF_HIGH_CYC};
      int n, ton, dead, toff;
      @(posedge core_clk);
      enable <= 1'b1;
      ext_reference <= 8'hFF;
      for (int i = 0; i < 3; i++) begin
         @(posedge core_clk);
         step_proportion <= props[i];
         @(negedge core_clk);
         wait_sw(1'b0, 1'b0, n);
         wait_sw(1'b0, 1'b1, n);
         wait_sw(1'b0, 1'b0, ton);
         wait_sw(1'b1, 1'b1, dead);
         wait_sw(1'b1, 1'b0, toff);
         `CHK(ton >= BLANK_LONG_CYC, 1'b1)
         `CHK(ton <= BLANK_LONG_CYC + 6, 1'b1)
         `CHK(dead, DEAD_CYC)
         `CHK(toff, exp_off[i])
      end
      `CHK(trip_reference, 16'h53AC)
   endtask
   // Clean interval in the middle must restart the hit count
   task automatic open_coil_run;
      bit pat [6] = '{1, 1, 0, 1, 1, 1};
      int n;
      @(posedge core_clk);
      step_proportion <= 8'hAA;
      enable <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         wait_sw(1'b1, 1'b1, n);
         @(posedge core_clk);
         open_coil <= pat[i];
         wait_sw(1'b1, 1'b0, n);
         @(posedge core_clk);
         open_coil <= 1'b0;
         if (i == 4) begin
            @(negedge core_clk);
            `CHK(fault_latches.open_f, 1'b0)
         end
      end
      repeat (4) @(negedge core_clk);
      `CHK({fault_latches, gates, fault}, 6'b010001)
   endtask
   // Cause is removed again; the latch must hold regardless
   task automatic trip_fault(input bit therm);
      @(posedge core_clk);
      enable <= 1'b1;
      repeat (30) @(posedge core_clk);
      over_temp <= therm;
      coil_short <= !therm;
      repeat (8) @(posedge core_clk);
      {over_temp, coil_short} <= 2'b00;
      repeat (40) @(negedge core_clk);
      if (therm) `CHK({fault_latches, gates, fault}, 6'b001001)
      else `CHK({fault_latches, gates, fault}, 6'b100001)
   endtask
   initial begin
      do_reset();
      chop_levels();
      do_reset();
      open_coil_run();
      do_reset();
      trip_fault(1'b0);
      do_reset();
      trip_fault(1'b1);
      tally_and_finish();
   end
   initial begin
      #(40 * 20000);
      failures++;
      tally_and_finish();
   end
endmodule
